//--- sram_port_cfg.svh
// constants for the flow-through synchronous sram port
`ifndef SRAM_PORT_CFG_SVH
`define SRAM_PORT_CFG_SVH

// bit positions inside the asynchronous input synchroniser vector
`define SYN_W          5
`define SYN_OE         0
`define SYN_SLEEP      1
`define SYN_TCK        2
`define SYN_MODE       3
`define SYN_TDI        4
// reset values: drive off, awake, test clock low, strap floating, tdi high
`define SYN_RST        5'h19
// clocks after reset release before the burst-order strap is latched;
// the filter needs four edges to show a pin, so the fifth edge catches it
`define STRAP_SETTLE   3'h5
`define STRAP_CNT_W    3
`define STRAP_STEP     3'h1

`endif

//--- sram_port_pkg.sv
// types for the flow-through synchronous sram port
package sram_port_pkg;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_READ  = 2'b01,
    ST_WRITE = 2'b10,
    ST_SLEEP = 2'b11
  } port_state_t;

endpackage

//--- sync_flowthrough_sram_port.sv
// device-side logic of a synchronous flow-through burst sram port
`include "sram_port_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module sync_flowthrough_sram_port #(
  parameter int ADDR_W = 10,
  parameter int BYTES  = 4,
  parameter int BYTE_W = 8
) (
  // clock and reset
  input  wire logic                      clk_i,
  input  wire logic                      rst_n_i,
  // synchronous control
  input  wire logic                      chip_sel_first_n_i,
  input  wire logic                      chip_sel_second_i,
  input  wire logic                      chip_sel_third_n_i,
  input  wire logic                      clk_qualify_n_i,
  input  wire logic                      write_req_n_i,
  input  wire logic                      burst_step_or_load_i,
  input  wire logic [BYTES-1:0]          byte_write_sel_n_i,
  input  wire logic [ADDR_W-1:0]         addr_i,
  // asynchronous control and strap
  input  wire logic                      out_drive_en_n_i,
  input  wire logic                      sleep_req_i,
  input  wire logic                      burst_order_strap_i,
  // data and parity pins
  input  wire logic [BYTES*BYTE_W-1:0]   data_io_lines_i,
  output logic      [BYTES*BYTE_W-1:0]   data_io_lines_o,
  output logic                           data_io_lines_oe_o,
  input  wire logic [BYTES-1:0]          parity_io_lines_i,
  output logic      [BYTES-1:0]          parity_io_lines_o,
  output logic                           parity_io_lines_oe_o,
  // serial test port
  input  wire logic                      test_clk_i,
  input  wire logic                      test_data_i,
  output logic                           test_data_o,
  // status
  output logic                           asleep_o
);

  localparam int DW    = BYTES * BYTE_W;
  localparam int DEPTH = 1 << ADDR_W;

  // ****************************************************************
  // asynchronous inputs
  // ****************************************************************
  logic [`SYN_W-1:0] syn1_reg;
  logic [`SYN_W-1:0] syn2_reg;
  logic [`SYN_W-1:0] syn3_reg;
  logic [`SYN_W-1:0] filt_reg;
  logic [`SYN_W-1:0] pins_w;

  assign pins_w = {test_data_i, burst_order_strap_i, test_clk_i,
                   sleep_req_i, out_drive_en_n_i};

  // a change counts only once stages two and three agree
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      syn1_reg <= `SYN_RST;
      syn2_reg <= `SYN_RST;
      syn3_reg <= `SYN_RST;
      filt_reg <= `SYN_RST;
    end else begin
      syn1_reg <= pins_w;
      syn2_reg <= syn1_reg;
      syn3_reg <= syn2_reg;
      for (int i = 0; i < `SYN_W; i++) begin
        if (syn2_reg[i] == syn3_reg[i]) begin
          filt_reg[i] <= syn3_reg[i];
        end
      end
    end
  end

  // ****************************************************************
  // burst-order strap
  // ****************************************************************
  logic [`STRAP_CNT_W-1:0] strap_cnt_reg;
  logic                    interleave_reg;

  // strap is caught once, after the synchroniser has settled
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strap_cnt_reg  <= '0;
      interleave_reg <= 1'b1;
    end else if (strap_cnt_reg != `STRAP_SETTLE) begin
      strap_cnt_reg  <= strap_cnt_reg + `STRAP_STEP;
      interleave_reg <= filt_reg[`SYN_MODE];
    end
  end

  function automatic logic [1:0] burst_lo(input logic [1:0] base,
                                          input logic [1:0] seq,
                                          input logic       inter);
    burst_lo = inter ? (base ^ seq) : (base + seq);
  endfunction

  // ****************************************************************
  // access control
  // ****************************************************************
  sram_port_pkg::port_state_t state_reg;
  sram_port_pkg::port_state_t state_next;
  logic [ADDR_W-1:0] base_reg;
  logic [ADDR_W-1:0] base_next;
  logic [1:0]        seq_reg;
  logic [1:0]        seq_next;
  logic [BYTES-1:0]  bw_reg;
  logic [BYTES-1:0]  bw_next;
  logic [ADDR_W-1:0] addr_reg;
  logic [ADDR_W-1:0] addr_next;
  logic              exit_reg;
  logic              exit_next;
  logic              drive_reg;
  logic              drive_next;
  logic              ce_w;
  logic              sel_w;

  // qualified edges only; sleep also freezes the port
  assign ce_w  = !clk_qualify_n_i && !filt_reg[`SYN_SLEEP];
  assign sel_w = !chip_sel_first_n_i && chip_sel_second_i &&
                 !chip_sel_third_n_i;

  always_comb begin
    state_next = state_reg;
    base_next  = base_reg;
    seq_next   = seq_reg;
    bw_next    = bw_reg;
    exit_next  = exit_reg;
    if (filt_reg[`SYN_SLEEP]) begin
      state_next = sram_port_pkg::ST_SLEEP;
      exit_next  = 1'b0;
    end else if (state_reg == sram_port_pkg::ST_SLEEP) begin
      state_next = sram_port_pkg::ST_IDLE;
    end else if (ce_w) begin
      bw_next = byte_write_sel_n_i;
      if (burst_step_or_load_i) begin
        // step the burst counter, selects not looked at
        if (state_reg != sram_port_pkg::ST_IDLE) begin
          seq_next = seq_reg + 2'h1;
        end
      end else if (sel_w) begin
        state_next = write_req_n_i ? sram_port_pkg::ST_READ
                                   : sram_port_pkg::ST_WRITE;
        base_next  = addr_i;
        seq_next   = 2'h0;
      end else begin
        state_next = sram_port_pkg::ST_IDLE;
      end
      exit_next = (state_reg == sram_port_pkg::ST_IDLE) &&
                  (state_next != sram_port_pkg::ST_IDLE);
    end
  end

  assign addr_next = {base_next[ADDR_W-1:2],
                      burst_lo(base_next[1:0], seq_next, interleave_reg)};

  // drive only on a read, outside the exit cycle, enable low
  assign drive_next = (state_next == sram_port_pkg::ST_READ) && !exit_next &&
                      !filt_reg[`SYN_OE];

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= sram_port_pkg::ST_IDLE;
      base_reg  <= '0;
      seq_reg   <= 2'h0;
      bw_reg    <= '1;
      addr_reg  <= '0;
      exit_reg  <= 1'b0;
      drive_reg <= 1'b0;
      asleep_o  <= 1'b0;
    end else begin
      state_reg <= state_next;
      base_reg  <= base_next;
      seq_reg   <= seq_next;
      bw_reg    <= bw_next;
      addr_reg  <= addr_next;
      exit_reg  <= exit_next;
      drive_reg <= drive_next;
      asleep_o  <= state_next == sram_port_pkg::ST_SLEEP;
    end
  end

  assign data_io_lines_oe_o   = drive_reg;
  assign parity_io_lines_oe_o = drive_reg;

  // ****************************************************************
  // storage array
  // ****************************************************************
  logic [DW-1:0]    mem_data [DEPTH];
  logic [BYTES-1:0] mem_par  [DEPTH];
  logic [DW-1:0]    rd_word_w;
  logic [BYTES-1:0] rd_par_w;
  logic             commit_w;

  assign rd_word_w = mem_data[addr_next];
  assign rd_par_w  = mem_par[addr_next];
  assign commit_w  = ce_w && (state_reg == sram_port_pkg::ST_WRITE);

  // write data taken from the pins on the edge after the address
  always_ff @(posedge clk_i) begin
    if (commit_w) begin
      for (int b = 0; b < BYTES; b++) begin
        if (!bw_reg[b]) begin
          mem_data[addr_reg][b*BYTE_W +: BYTE_W] <=
            data_io_lines_i[b*BYTE_W +: BYTE_W];
          mem_par[addr_reg][b] <= parity_io_lines_i[b];
        end
      end
    end
  end

  // flow-through: word of the address taken at this edge
  // a read of the word written at the same edge returns the old value
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_io_lines_o   <= '0;
      parity_io_lines_o <= '0;
    end else if (ce_w) begin
      data_io_lines_o   <= rd_word_w;
      parity_io_lines_o <= rd_par_w;
    end
  end

  // ****************************************************************
  // serial test output
  // ****************************************************************
  logic tdi_cap_reg;
  logic tck_rise_w;
  logic tck_fall_w;

  assign tck_rise_w = (syn2_reg[`SYN_TCK] == syn3_reg[`SYN_TCK]) &&
                      syn3_reg[`SYN_TCK] && !filt_reg[`SYN_TCK];
  assign tck_fall_w = (syn2_reg[`SYN_TCK] == syn3_reg[`SYN_TCK]) &&
                      !syn3_reg[`SYN_TCK] && filt_reg[`SYN_TCK];

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tdi_cap_reg <= 1'b1;
      test_data_o <= 1'b1;
    end else begin
      if (tck_rise_w) begin
        tdi_cap_reg <= syn3_reg[`SYN_TDI];
      end
      // output moves on the falling test clock
      if (tck_fall_w) begin
        test_data_o <= tdi_cap_reg;
      end
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  logic par0_w;
  assign par0_w = parity_io_lines_i[0];

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_load_sel;
    ce_w && !burst_step_or_load_i && sel_w;
  endsequence

  sequence s_read_taken;
    ce_w && state_next == sram_port_pkg::ST_READ;
  endsequence

  a_sel_decode: assert property (
    s_load_sel |=> state_reg != sram_port_pkg::ST_IDLE && exit_reg ==
      ($past(state_reg) == sram_port_pkg::ST_IDLE))
    else $error("selection not taken");

  a_enable_off: assert property (
    filt_reg[`SYN_OE] |=> !data_io_lines_oe_o && !parity_io_lines_oe_o)
    else $error("drive with output enable high");

  a_write_quiet: assert property (
    state_reg != sram_port_pkg::ST_READ || exit_reg |-> !data_io_lines_oe_o)
    else $error("drive in write, exit or deselect");

  a_stall_hold: assert property (
    clk_qualify_n_i && !filt_reg[`SYN_SLEEP] && state_reg !=
      sram_port_pkg::ST_SLEEP |=> $stable(state_reg) && $stable(addr_reg))
    else $error("state moved on unqualified edge");

  a_sleep_enter: assert property (
    filt_reg[`SYN_SLEEP] |=> state_reg == sram_port_pkg::ST_SLEEP ##0 asleep_o)
    else $error("sleep not entered");

  a_write_commit: assert property (
    commit_w && !bw_reg[0] |=> mem_par[$past(addr_reg)][0] == $past(par0_w))
    else $error("parity byte 0 not stored");

  a_flow_read: assert property (
    s_read_taken |=> data_io_lines_o == $past(rd_word_w))
    else $error("read data not from taken address");

  a_burst_step: assert property (
    ce_w && burst_step_or_load_i && state_reg != sram_port_pkg::ST_IDLE &&
      state_reg != sram_port_pkg::ST_SLEEP && !filt_reg[`SYN_SLEEP]
      |=> seq_reg == $past(seq_reg) + 2'h1)
    else $error("burst counter did not step");

  a_test_fall: assert property (
    $changed(test_data_o) |-> $fell(filt_reg[`SYN_TCK]))
    else $error("test output moved off falling edge");

endmodule

`default_nettype wire

//--- bus_pin_model.sv
// host-side model of one shared data pin group
`timescale 1ns/1ps
`default_nettype none

module bus_pin_model #(
  parameter int W = 8
) (
  // clock
  input  wire logic         clk_i,
  // device side
  input  wire logic         dev_oe_i,
  input  wire logic [W-1:0] dev_d_i,
  // host side
  input  wire logic         host_oe_i,
  input  wire logic [W-1:0] host_d_i,
  // resolved wire
  output logic      [W-1:0] pin_o,
  output logic              clash_o
);
  logic [W-1:0] last_reg = '0;

  // ************************************
  // wire resolution
  // ************************************
  // no keeper: a released wire must not look like held data
  always @(posedge clk_i) begin
    last_reg <= pin_o;
  end

  always_comb begin
    if (dev_oe_i) begin
      pin_o = dev_d_i;
    end else if (host_oe_i) begin
      pin_o = host_d_i;
    end else begin
      pin_o = ~last_reg;
    end
  end

  assign clash_o = dev_oe_i & host_oe_i;
endmodule

`default_nettype wire

//--- testbench.sv
// self-checking bench for the flow-through sram port
`timescale 1ns/1ps
`default_nettype none

module testbench;
  // ************************************
  // pins and bookkeeping
  // ************************************
  // selected pattern
  localparam logic [2:0] SEL = 3'b010;
  logic        clk_i = 1'b0;
  logic        rst_n = 1'b0;
  logic [2:0]  sel = 3'b110;
  logic        we_n = 1'b1;
  logic        step = 1'b0;
  logic        qual_n = 1'b0;
  logic        oe_n = 1'b0;
  logic        sleep = 1'b0;
  logic        strap = 1'b1;
  logic        tck = 1'b0;
  logic        tdi = 1'b1;
  logic        host_oe = 1'b0;
  logic [9:0]  addr = 10'h0;
  logic [3:0]  bw = 4'hf;
  logic [3:0]  host_p = 4'h0;
  logic [3:0]  wp = 4'h0;
  logic [31:0] host_d = 32'h0;
  logic [31:0] wd = 32'h0;
  wire  [31:0] d_o, d_pin;
  wire  [3:0]  p_o, p_pin;
  wire         d_oe, p_oe, tdo, asleep, clash_d, clash_p;
  int          fails = 0;
  int          checks_done = 0;

  sync_flowthrough_sram_port dut_u (
    .clk_i(clk_i), .rst_n_i(rst_n),
    .chip_sel_first_n_i(sel[2]), .chip_sel_second_i(sel[1]),
    .chip_sel_third_n_i(sel[0]), .clk_qualify_n_i(qual_n),
    .write_req_n_i(we_n), .burst_step_or_load_i(step),
    .byte_write_sel_n_i(bw), .addr_i(addr),
    .out_drive_en_n_i(oe_n), .sleep_req_i(sleep),
    .burst_order_strap_i(strap),
    .data_io_lines_i(d_pin), .data_io_lines_o(d_o),
    .data_io_lines_oe_o(d_oe), .parity_io_lines_i(p_pin),
    .parity_io_lines_o(p_o), .parity_io_lines_oe_o(p_oe),
    .test_clk_i(tck), .test_data_i(tdi), .test_data_o(tdo),
    .asleep_o(asleep)
  );
  bus_pin_model #(.W(32)) pd_u (.clk_i(clk_i), .dev_oe_i(d_oe),
    .dev_d_i(d_o), .host_oe_i(host_oe), .host_d_i(host_d),
    .pin_o(d_pin), .clash_o(clash_d));
  bus_pin_model #(.W(4)) pp_u (.clk_i(clk_i), .dev_oe_i(p_oe),
    .dev_d_i(p_o), .host_oe_i(host_oe), .host_d_i(host_p),
    .pin_o(p_pin), .clash_o(clash_p));

  initial begin
    forever #4 clk_i = ~clk_i;
  end

  // ************************************
  // shared tasks
  // ************************************
  task automatic summarize;
    if (fails == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic chk_rd(input logic [31:0] d, input logic [3:0] p,
                        input logic oe);
    chk(d_o, d);
    chk(32'(p_o), 32'(p));
    chk(d_oe, oe);
    chk(p_oe, oe);
  endtask

  // results of one request show after the next call returns
  task automatic op(input logic [2:0] s, input logic w, st,
                    input logic [9:0] a, input logic [3:0] b,
                    input logic q, h);
    @(posedge clk_i);
    sel <= s;
    we_n <= w;
    step <= st;
    addr <= a;
    bw <= b;
    qual_n <= q;
    host_oe <= h;
    host_d <= wd;
    host_p <= wp;
    @(negedge clk_i);
    chk(32'(clash_d | clash_p), 32'h0);
  endtask

  task automatic rd(input logic [9:0] a, input logic h);
    op(SEL, 1'b1, 1'b0, a, 4'hf, 1'b0, h);
  endtask

  task automatic wr(input logic [9:0] a, input logic [3:0] b,
                    input logic h);
    op(SEL, 1'b0, 1'b0, a, b, 1'b0, h);
  endtask

  task automatic des(input logic h);
    op(3'b110, 1'b1, 1'b0, 10'h0, 4'hf, 1'b0, h);
  endtask

  task automatic do_reset(input logic st);
    @(posedge clk_i);
    rst_n <= 1'b0;
    strap <= st;
    repeat (12) @(posedge clk_i);
    @(negedge clk_i);
    chk(d_oe, 1'b0);
    chk(asleep, 1'b0);
    @(posedge clk_i);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk_i);
  endtask

  task automatic wait_sleep(input logic v);
    for (int n = 0; n < 12 && asleep !== v; n++) begin
      @(negedge clk_i);
    end
    if (asleep !== v) begin
      fails++;
      summarize;
    end else begin
      chk(asleep, v);
    end
  endtask

  // ************************************
  // scenarios
  // ************************************
  task automatic t_port;
    @(negedge clk_i);
    chk(tdo, 1'b1);
    @(posedge clk_i);
    tdi <= 1'b0;
    tck <= 1'b1;
    repeat (8) @(negedge clk_i);
    chk(tdo, 1'b1);
    @(posedge clk_i);
    tck <= 1'b0;
    repeat (8) @(negedge clk_i);
    chk(tdo, 1'b0);
  endtask

  task automatic t_wr_rd;
    des(1'b0);
    wd = 32'h1234_5678;
    wp = 4'h5;
    wr(10'h4, 4'h0, 1'b0);
    wr(10'h5, 4'h0, 1'b1);
    chk(d_oe, 1'b0);
    wd = 32'h9abc_def0;
    wp = 4'ha;
    rd(10'h4, 1'b1);
    chk(p_oe, 1'b0);
    rd(10'h5, 1'b0);
    chk_rd(32'h1234_5678, 4'h5, 1'b1);
    des(1'b0);
    chk_rd(32'h9abc_def0, 4'ha, 1'b1);
    rd(10'h4, 1'b0);
    chk(d_oe, 1'b0);
    des(1'b0);
    chk_rd(32'h1234_5678, 4'h5, 1'b0);
  endtask

  task automatic t_sel;
    logic [2:0] pats [3] = '{3'b110, 3'b000, 3'b011};
    for (int i = 0; i < 3; i++) begin
      rd(10'h5, 1'b0);
      rd(10'h5, 1'b0);
      op(pats[i], 1'b1, 1'b0, 10'h5, 4'hf, 1'b0, 1'b0);
      chk(d_oe, 1'b1);
      des(1'b0);
      chk(d_oe, 1'b0);
    end
  endtask

  task automatic t_byte;
    wd = 32'h1122_3344;
    wp = 4'h8;
    wr(10'h4, 4'b0101, 1'b0);
    des(1'b1);
    rd(10'h4, 1'b0);
    des(1'b0);
    chk_rd(32'h1134_3378, 4'hd, 1'b0);
  endtask

  task automatic t_oe;
    @(posedge clk_i);
    oe_n <= 1'b1;
    repeat (5) @(posedge clk_i);
    rd(10'h4, 1'b0);
    rd(10'h4, 1'b0);
    des(1'b0);
    chk(d_oe, 1'b0);
    @(posedge clk_i);
    oe_n <= 1'b0;
    repeat (5) @(posedge clk_i);
  endtask

  task automatic t_qual;
    rd(10'h4, 1'b0);
    rd(10'h5, 1'b0);
    op(SEL, 1'b1, 1'b0, 10'h4, 4'hf, 1'b1, 1'b0);
    des(1'b0);
    chk_rd(32'h9abc_def0, 4'ha, 1'b1);
    des(1'b0);
    chk(d_oe, 1'b0);
  endtask

  task automatic t_sleep;
    @(posedge clk_i);
    sleep <= 1'b1;
    wait_sleep(1'b1);
    wd = 32'h0;
    wp = 4'h0;
    wr(10'h4, 4'h0, 1'b0);
    des(1'b1);
    chk(d_oe, 1'b0);
    @(posedge clk_i);
    sleep <= 1'b0;
    wait_sleep(1'b0);
    repeat (2) @(posedge clk_i);
    rd(10'h4, 1'b0);
    des(1'b0);
    chk(d_o, 32'h1134_3378);
  endtask

  task automatic t_burst(input logic st);
    logic [1:0] lo;
    do_reset(st);
    for (int k = 0; k < 5; k++) begin
      wd = 32'h5a00_0000 + 32'(k) - 32'h1;
      wp = 4'(k - 1);
      if (k < 4) begin
        wr(10'(8 + k), 4'h0, k > 0);
      end else begin
        des(1'b1);
      end
    end
    for (int k = 0; k < 5; k++) begin
      if (k == 0) begin
        rd(10'h9, 1'b0);
      end else if (k < 4) begin
        op(SEL, 1'b1, 1'b1, 10'h0, 4'hf, 1'b0, 1'b0);
      end else begin
        des(1'b0);
      end
      lo = st ? 2'h1 ^ 2'(k - 1) : 2'h1 + 2'(k - 1);
      if (k > 0) chk(d_o, 32'h5a00_0000 + 32'(lo));
    end
  endtask

  initial begin
    do_reset(1'b1);
    t_port;
    t_wr_rd;
    t_sel;
    t_byte;
    t_oe;
    t_qual;
    t_sleep;
    t_burst(1'b1);
    t_burst(1'b0);
    summarize;
  end
endmodule

`default_nettype wire
